// file: hdl/gcu_pkg.sv
// shared constants and types for the general counter unit pair
package gcu_pkg;
  localparam int          GCU_NUM         = 2;          // independent counters
  localparam int          GCU_WIDTH       = 24;         // count register width
  localparam int          GCU_INC_WIDTH   = 8;          // reload increment width
  localparam int          GCU_FIFO_DEPTH  = 8;          // points held on chip
  localparam int          GCU_CONN_LINES  = 10;         // connector input lines
  localparam int          GCU_TRIG_LINES  = 7;          // system trigger lines
  localparam int          GCU_EXT_LINES   = 19;         // connector + trigger + two section triggers
  localparam int          GCU_DIO_CTR0    = 6;          // direction line for counter 0
  localparam int          GCU_DIO_CTR1    = 7;          // direction line for counter 1
  localparam logic [4:0]  GCU_SEL_TRIG    = 5'h0a;      // first system trigger code
  localparam logic [4:0]  GCU_SEL_BEGIN   = 5'h11;      // input section begin trigger code
  localparam logic [4:0]  GCU_SEL_END     = 5'h12;      // input section end trigger code
  localparam logic [4:0]  GCU_SEL_SIBLING = 5'h13;      // other counter (tc as source, output as gate)
  localparam logic [23:0] GCU_MIN_WIDTH   = 24'h000002; // shortest pulse width count
  localparam logic [23:0] GCU_ONE         = 24'h000001; // unit step
  localparam logic [23:0] GCU_COUNT_RST   = 24'h000000; // count after reset or halt

  // application the counter runs
  typedef enum logic [2:0] {
    simple_event_counting   = 3'h0,
    buffered_event_counting = 3'h1,
    buffered_period_measure = 3'h2,
    pulse_train_generation  = 3'h3,
    frequency_shift_keying  = 3'h4
  } gcu_app_type;

  // control actions
  typedef enum logic [2:0] {
    action_none           = 3'h0,
    configure_without_arm = 3'h1,
    arm_action            = 3'h2,
    configure_and_arm     = 3'h3,
    halt_and_clear        = 3'h4,
    direction_upward      = 3'h5,
    direction_downward    = 3'h6
  } gcu_action_type;

  // run state of one counter
  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_ready = 2'h1,
    st_armed = 2'h2
  } gcu_state_type;

  // output phase during generation
  typedef enum logic {
    ph_low  = 1'b0,
    ph_high = 1'b1
  } gcu_phase_type;

  // parameter set; bit fields: 1 = falling edge / negative / line driven / down / strobe
  typedef struct packed {
    gcu_app_type                app;
    logic [4:0]                 count_source_select;
    logic                       source_edge_select;
    logic [4:0]                 gate_select;
    logic                       gate_polarity_select;
    logic                       gate_enable;
    logic [GCU_WIDTH-1:0]       initial_count_value;
    logic [GCU_WIDTH-1:0]       width_count_one;
    logic [GCU_WIDTH-1:0]       width_count_two;
    logic [GCU_WIDTH-1:0]       width_count_three;
    logic [GCU_WIDTH-1:0]       width_count_four;
    logic [GCU_INC_WIDTH-1:0]   reload_increment_amount;
    logic                       direction_control_select;
    logic                       direction_downward;
    logic                       output_behaviour_select;
    logic                       output_idle_level_select;
  } gcu_cfg_type;

  // one buffered data point
  typedef struct packed {
    logic                 unit;
    logic [GCU_WIDTH-1:0] value;
  } gcu_point_type;
endpackage

// file: hdl/gcu_counter_pair.sv
// two general counter units with buffered point output
`timescale 1ns/1ps

// fifo of flip-flops, width and depth set by parameters
module gcu_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room left
  output logic [WIDTH-1:0]      out_data,  // oldest word
  output logic                  out_valid, // word available
  input  wire logic             out_ready  // drain accepts
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr;        // write index
  logic [AW-1:0]    rd_ptr;        // read index
  logic [AW:0]      fill;          // words held
  logic             do_wr;         // write this cycle
  logic             do_rd;         // read this cycle

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level; depth is a power of two so pointers wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(do_wr);
      rd_ptr <= rd_ptr + AW'(do_rd);
      fill   <= fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

module gcu_counter_pair (
  input  wire logic                                      sys_clk,                     // system clock
  input  wire logic                                      rst,                         // async reset, high
  input  wire logic [gcu_pkg::GCU_CONN_LINES-1:0]        connector_input_line,        // connector pins
  input  wire logic [gcu_pkg::GCU_TRIG_LINES-1:0]        system_trigger_line,         // system triggers
  input  wire logic                                      input_section_begin_trigger, // section start
  input  wire logic                                      input_section_end_trigger,   // section stop
  input  wire logic [7:0]                                dio_line,                    // digital lines
  input  wire gcu_pkg::gcu_cfg_type [1:0]                cfg,                         // parameter sets
  input  wire gcu_pkg::gcu_action_type [1:0]             action,                      // per-counter action
  output logic [1:0]                                     counter_out,                 // output pins
  output logic [1:0][gcu_pkg::GCU_WIDTH-1:0]             count_value,                 // live counts
  output logic [1:0]                                     armed,                       // counter running
  output logic [1:0]                                     overflow,                    // point lost
  output gcu_pkg::gcu_point_type                         point_data,                  // buffered point
  output logic                                           point_valid,                 // point offered
  input  wire logic                                      point_ready                  // host accepts
);
  import gcu_pkg::*;

  localparam int NSYNC = GCU_EXT_LINES + 2;

  logic [NSYNC-1:0]         sync1;       // first stage, read only by sync2
  logic [NSYNC-1:0]         sync2;       // second stage
  logic [NSYNC-1:0]         sync3;       // third stage
  logic [NSYNC-1:0]         filt;        // settled line levels
  logic [GCU_EXT_LINES-1:0] ext;         // settled selectable lines
  logic [1:0]               dir_line;    // settled direction lines
  logic [1:0]               tc_q;        // registered terminal count
  logic [1:0]               pend;        // point waiting per counter
  logic [1:0]               take;        // point moved into fifo
  gcu_point_type            pend_val [2];// waiting points
  gcu_point_type            fifo_in;     // arbitrated point
  gcu_point_type            fifo_out;    // fifo head
  logic                     fifo_in_rdy; // fifo has room
  logic                     fifo_out_vld;// fifo not empty
  logic                     fifo_out_rdy;// output stage can take

  // pick one selectable line or the sibling signal
  function automatic logic pick(input logic [4:0] sel, input logic [GCU_EXT_LINES-1:0] lines,
                                input logic sib);
    logic r;
    r = 1'b0;
    if (sel == GCU_SEL_SIBLING) begin
      r = sib;
    end else if (sel < GCU_SEL_SIBLING) begin
      r = lines[sel];
    end
    return r;
  endfunction

  // widths below the minimum are raised to it
  function automatic logic [GCU_WIDTH-1:0] wclamp(input logic [GCU_WIDTH-1:0] w);
    return (w < GCU_MIN_WIDTH) ? GCU_MIN_WIDTH : w;
  endfunction

  // three-stage input filter; a change is taken once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end else begin
      sync1 <= {dio_line[GCU_DIO_CTR1], dio_line[GCU_DIO_CTR0], input_section_end_trigger,
                input_section_begin_trigger, system_trigger_line, connector_input_line};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end
  end

  assign ext      = filt[GCU_EXT_LINES-1:0];
  assign dir_line = filt[NSYNC-1:GCU_EXT_LINES];

  genvar gi;
  generate
    for (gi = 0; gi < GCU_NUM; gi++) begin : g_unit
      gcu_cfg_type          act;        // parameters in force
      gcu_state_type        st;         // run state
      gcu_phase_type        phase;      // generation phase
      logic [GCU_WIDTH-1:0] cnt;        // count register
      logic [GCU_WIDTH-1:0] c1;         // live count-one value
      logic                 sw_down;    // software direction, 1 = down
      logic                 src_prev;   // last source level
      logic                 gate_prev;  // last gate level
      logic                 tog;        // toggle state of output
      logic                 src_now;    // selected source level
      logic                 gate_lvl;   // gate after polarity
      logic                 tick;       // counted source edge
      logic                 gen;        // generation application
      logic                 evt;        // event counting application
      logic                 down;       // effective direction
      logic                 run_ok;     // counting allowed now
      logic                 tc_now;     // terminal count this cycle
      logic                 push;       // capture a point
      logic                 prep;       // prepare action
      logic [GCU_WIDTH-1:0] w_hi;       // width for high phase
      logic [GCU_WIDTH-1:0] w_lo;       // width for next low phase

      // sibling source is its terminal count, sibling gate its output pin
      assign src_now  = pick(act.count_source_select, ext, tc_q[1-gi]);
      assign gate_lvl = pick(act.gate_select, ext, counter_out[1-gi]) ^ act.gate_polarity_select;
      assign tick     = act.source_edge_select ? (src_prev & ~src_now) : (~src_prev & src_now);
      assign gen      = (act.app == pulse_train_generation) | (act.app == frequency_shift_keying);
      assign evt      = (act.app == simple_event_counting) | (act.app == buffered_event_counting);
      // hardware direction samples the counter's own digital line
      assign down     = gen | (act.direction_control_select ? ~dir_line[gi] : sw_down);
      // period and fsk use the gate for their own purpose, not as an enable
      assign run_ok   = (st == st_armed) & ((act.app == buffered_period_measure) |
                        (act.app == frequency_shift_keying) | ~act.gate_enable | gate_lvl);
      assign tc_now   = tick & run_ok & down & (cnt == GCU_ONE);
      assign push     = (st == st_armed) & gate_lvl & ~gate_prev &
                        ((act.app == buffered_event_counting) | (act.app == buffered_period_measure));
      assign prep     = (action[gi] == configure_without_arm) | (action[gi] == configure_and_arm);
      // fsk: gate inactive selects widths three and four
      assign w_hi     = (act.app == frequency_shift_keying & ~gate_lvl) ? act.width_count_four
                                                                        : act.width_count_two;
      assign w_lo     = (act.app == frequency_shift_keying & ~gate_lvl) ? act.width_count_three
                                                                        : c1 + {16'h0000, act.reload_increment_amount};

      // parameter capture and run state; host edits cfg freely until prepare
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          act <= '0;
          st  <= st_idle;
        end else begin
          if (prep) begin
            act <= cfg[gi];
          end
          unique case (action[gi])
            configure_without_arm: st <= st_ready;
            configure_and_arm:     st <= st_armed;
            arm_action:            st <= (st == st_idle) ? st_idle : st_armed;
            halt_and_clear:        st <= st_idle;
            default:               st <= st;
          endcase
        end
      end

      // software direction: default up, preset at prepare, changed by actions in event counting
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sw_down <= 1'b0;
        end else if (prep) begin
          sw_down <= cfg[gi].direction_downward;
        end else if (evt & ~act.direction_control_select) begin
          if (action[gi] == direction_upward) begin
            sw_down <= 1'b0;
          end else if (action[gi] == direction_downward) begin
            sw_down <= 1'b1;
          end
        end
      end

      // count register, phase and auto-incremented count one
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt   <= GCU_COUNT_RST;
          c1    <= GCU_COUNT_RST;
          phase <= ph_low;
        end else if (prep) begin
          phase <= ph_low;
          c1    <= cfg[gi].width_count_one;
          // generation starts on the first low phase, counting starts from the initial value
          if ((cfg[gi].app == pulse_train_generation) | (cfg[gi].app == frequency_shift_keying)) begin
            cnt <= wclamp((cfg[gi].app == frequency_shift_keying) ? cfg[gi].width_count_three
                                                                   : cfg[gi].width_count_one);
          end else begin
            cnt <= cfg[gi].initial_count_value;
          end
        end else if (action[gi] == halt_and_clear) begin
          cnt <= GCU_COUNT_RST;
        end else if (push & (act.app == buffered_period_measure)) begin
          // period restart; a source edge in this cycle is counted in the new period
          cnt <= tick ? GCU_ONE : GCU_COUNT_RST;
        end else if (gen & tc_now) begin
          phase <= (phase == ph_low) ? ph_high : ph_low;
          if (phase == ph_low) begin
            cnt <= wclamp(w_hi);
          end else begin
            cnt <= wclamp(w_lo);
            if (~(act.app == frequency_shift_keying & ~gate_lvl)) begin
              c1 <= w_lo;
            end
          end
        end else if (tick & run_ok) begin
          cnt <= down ? cnt - GCU_ONE : cnt + GCU_ONE;
        end
      end

      // output pin: toggle or one-clock strobe, then idle level
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          tog             <= 1'b0;
          counter_out[gi] <= 1'b0;
          tc_q[gi]        <= 1'b0;
        end else if (prep | (action[gi] == halt_and_clear)) begin
          tog             <= 1'b0;
          counter_out[gi] <= prep ? cfg[gi].output_idle_level_select : act.output_idle_level_select;
          tc_q[gi]        <= 1'b0;
        end else begin
          tog             <= tog ^ tc_now;
          counter_out[gi] <= (act.output_behaviour_select ? tc_now : tog ^ tc_now)
                             ^ act.output_idle_level_select;
          tc_q[gi]        <= tc_now;
        end
      end

      // edge history and status
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          src_prev        <= 1'b0;
          gate_prev       <= 1'b0;
          armed[gi]       <= 1'b0;
          count_value[gi] <= GCU_COUNT_RST;
        end else begin
          src_prev        <= src_now;
          gate_prev       <= gate_lvl;
          armed[gi]       <= (st == st_armed);
          count_value[gi] <= cnt;
        end
      end

      // waiting point; a new capture wins over the hand-off, a capture onto a stuck point overwrites it
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pend[gi]     <= 1'b0;
          pend_val[gi] <= '0;
          overflow[gi] <= 1'b0;
        end else begin
          if (push) begin
            pend[gi]     <= 1'b1;
            pend_val[gi] <= '{unit: 1'(gi), value: cnt};
          end else if (take[gi]) begin
            pend[gi]     <= 1'b0;
          end
          if (push & pend[gi] & ~take[gi]) begin
            overflow[gi] <= 1'b1;
          end else if (prep) begin
            overflow[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // counter 0 has priority into the fifo; a full fifo holds both points back
  assign take    = {pend[1] & ~pend[0], pend[0]} & {2{fifo_in_rdy}};
  assign fifo_in = pend[0] ? pend_val[0] : pend_val[1];

  gcu_fifo #(
    .WIDTH ($bits(gcu_point_type)),
    .DEPTH (GCU_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (pend[0] | pend[1]),
    .in_ready  (fifo_in_rdy),
    .out_data  (fifo_out),
    .out_valid (fifo_out_vld),
    .out_ready (fifo_out_rdy)
  );

  assign fifo_out_rdy = ~point_valid | point_ready;

  // registered output stage toward the host
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      point_valid <= 1'b0;
      point_data  <= '0;
    end else if (fifo_out_rdy) begin
      point_valid <= fifo_out_vld;
      point_data  <= fifo_out;
    end
  end
endmodule

// file: verification/gcu_partner_model.sv
// far-side model: timing lines and host drain for the counter pair
`timescale 1ns/1ps
module gcu_partner_model (
  input  wire logic  sys_clk, // clock
  input  wire logic  stall,   // host holds off
  output logic [9:0] line,    // connector lines
  output logic       ready    // host accepts
);
  logic slow; // drain every other cycle
  initial begin
    line = 10'h000;
    ready = 1'b0;
    slow = 1'b0;
  end
  // host drains slowly, never while stalled, so the buffer sees back-pressure
  always @(negedge sys_clk) begin
    slow <= ~slow;
    ready <= ~stall & slow;
  end
  // n pulses on masked lines, each level held long enough to pass the input filter
  task pulse(input logic [9:0] mask, input int n);
    repeat (n) begin
      @(negedge sys_clk) line = line | mask;
      repeat (10) @(negedge sys_clk);
      line = line & ~mask;
      repeat (10) @(negedge sys_clk);
    end
  endtask
endmodule

// file: verification/gcu_counter_pair_checker.sv
// port assertions for the counter pair
`timescale 1ns/1ps
module gcu_counter_pair_checker
  import gcu_pkg::*;
(
  input wire logic                          sys_clk,     // clock
  input wire logic                          rst,         // reset
  input wire gcu_pkg::gcu_cfg_type [1:0]    cfg,         // settings
  input wire gcu_pkg::gcu_action_type [1:0] action,      // actions
  input wire logic [1:0]                    counter_out, // pins
  input wire logic [1:0][GCU_WIDTH-1:0]     count_value, // counts
  input wire logic [1:0]                    armed,       // running
  input wire logic [1:0]                    overflow,    // point lost
  input wire gcu_pkg::gcu_point_type        point_data,  // point
  input wire logic                          point_valid, // offered
  input wire logic                          point_ready  // taken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |-> armed == 2'h0 && point_valid == 1'b0 && counter_out == 2'h0) else $error("output active in reset");
  a_arm_delay: assert property (
    action[0] == configure_and_arm ##1 action[0] == action_none |-> ##1 armed[0]) else $error("arm late");
  a_halt_clear: assert property (
    action[0] == halt_and_clear ##1 action[0] == action_none |-> ##1 !armed[0] && count_value[0] == 24'h0)
    else $error("halt left counter running");
  a_point_hold: assert property (
    point_valid && !point_ready |=> point_valid && $stable(point_data)) else $error("point dropped");
  a_overflow_keep: assert property (
    overflow[0] && action[0] != configure_without_arm && action[0] != configure_and_arm |=> overflow[0])
    else $error("overflow not sticky");
  a_idle_level: assert property (
    action[0] == configure_and_arm ##1 action[0] == action_none |-> ##1
    counter_out[0] == cfg[0].output_idle_level_select) else $error("wrong idle level");
  a_count_step: assert property (
    armed[1] && cfg[1].app == simple_event_counting && action[1] == action_none && $past(action[1]) == action_none
    && $past(action[1], 2) == action_none |=> (count_value[1] - $past(count_value[1])) inside {24'h0, 24'h1, 24'hffffff})
    else $error("count jumped");
  a_strobe_once: assert property (
    cfg[1].output_behaviour_select && !cfg[1].output_idle_level_select && $rose(counter_out[1]) |=> !counter_out[1])
    else $error("strobe too long");
endmodule

// file: verification/gcu_counter_pair_bench.sv
// self-checking bench for the general counter unit pair
`timescale 1ns/1ps
module gcu_counter_pair_bench;
  import gcu_pkg::*;
  logic                 sys_clk = 1'b0;                 // clock
  logic                 rst = 1'b0;                     // reset, high
  logic [7:0]           dio = 8'h00;                    // direction lines
  logic [8:0]           trig = 9'h000;                  // trigger lines, section begin and end
  logic                 stall = 1'b1;                   // host holds off
  logic [9:0]           line;                           // connector lines
  logic                 ready;                          // host accepts
  gcu_cfg_type [1:0]    cfg = '0;                       // settings
  gcu_action_type [1:0] action = '{action_none, action_none}; // actions
  logic [1:0]           counter_out, armed, overflow;   // status
  logic [1:0][23:0]     count_value;                    // counts
  gcu_point_type        point_data;                     // drained point
  logic                 point_valid;                    // offered
  integer               seed = 32'hb4c41ee8;            // fixed seed
  int                   mismatches = 0, comparisons = 0, pops = 0, r, ic, e0, e1, w1, w2, inc;
  logic [23:0]          expq[$];                        // points owed
  gcu_counter_pair i_gcu_counter_pair (.sys_clk(sys_clk), .rst(rst), .connector_input_line(line),
    .system_trigger_line(trig[6:0]), .input_section_begin_trigger(trig[7]), .input_section_end_trigger(trig[8]),
    .dio_line(dio), .cfg(cfg), .action(action), .counter_out(counter_out), .count_value(count_value),
    .armed(armed), .overflow(overflow), .point_data(point_data), .point_valid(point_valid), .point_ready(ready));
  gcu_partner_model i_gcu_partner_model (.sys_clk(sys_clk), .stall(stall), .line(line), .ready(ready));
  always #2 sys_clk = ~sys_clk;
  // one compare, reported at once when it differs
  task chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // one-cycle action pulse, then settle
  task act(input int u, input gcu_action_type a);
    @(negedge sys_clk) action[u] = a;
    @(negedge sys_clk) action[u] = action_none;
    repeat (4) @(negedge sys_clk);
  endtask
  // gate pulse on line 2; the count so far is owed as a point
  task gate;
    expq.push_back(e0[23:0]);
    i_gcu_partner_model.pulse(10'h004, 1);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // every taken point is compared against the model queue
  always @(posedge sys_clk) begin
    if (!rst && point_valid === 1'b1 && ready === 1'b1) begin
      pops++;
      if (expq.size() > 0) chk("point", point_data.value, expq.pop_front());
      chk("unit", point_data.unit, 24'h0);
    end
  end
  initial begin
    #1 rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    chk("armed", armed, 24'h0);
    r = $random(seed);
    ic = r & 24'hffffff;
    e0 = ic;
    e1 = ic;
    cfg[0].initial_count_value = ic[23:0];
    cfg[1] = cfg[0];
    cfg[1].count_source_select = 5'h01;
    cfg[1].source_edge_select = 1'b1;
    cfg[1].direction_downward = 1'b1;
    act(0, configure_and_arm);
    act(1, configure_and_arm);
    i_gcu_partner_model.pulse(10'h003, 5);
    act(1, direction_upward);
    i_gcu_partner_model.pulse(10'h003, 3);
    e0 += 8;
    e1 += 3 - 5;
    chk("count0", count_value[0], e0[23:0]);
    chk("count1", count_value[1], e1[23:0]);
    $display("test event counting done");
    act(0, halt_and_clear);
    chk("halted", count_value[0], 24'h0);
    cfg[0].direction_control_select = 1'b1;
    cfg[0].gate_enable = 1'b1;
    cfg[0].gate_select = GCU_SEL_END;
    trig[8] = 1'b1;
    act(0, configure_and_arm);
    act(0, direction_upward);
    i_gcu_partner_model.pulse(10'h001, 4);
    dio[6] = 1'b1;
    repeat (8) @(negedge sys_clk);
    i_gcu_partner_model.pulse(10'h001, 2);
    trig[8] = 1'b0;
    repeat (8) @(negedge sys_clk);
    i_gcu_partner_model.pulse(10'h001, 3);
    e0 = ic - 2;
    chk("line dir", count_value[0], e0[23:0]);
    $display("test line direction done");
    cfg[0] = '0;
    cfg[0].app = buffered_event_counting;
    cfg[0].gate_select = 5'h02;
    act(0, configure_and_arm);
    e0 = 0;
    stall = 1'b0;
    for (int i = 1; i < 4; i++) begin
      i_gcu_partner_model.pulse(10'h001, i);
      e0 += i;
      gate();
    end
    repeat (20) @(negedge sys_clk);
    chk("drained", pops[23:0], 24'h3);
    stall = 1'b1;
    repeat (12) gate();
    chk("overflow", overflow[0], 24'h1);
    stall = 1'b0;
    repeat (60) @(negedge sys_clk);
    chk("kept", pops[23:0], 24'hd);
    expq.delete();
    act(0, configure_without_arm);
    chk("ovf clear", overflow[0], 24'h0);
    $display("test buffering done");
    act(0, halt_and_clear);
    act(1, halt_and_clear);
    r = $random(seed);
    w1 = 2 + (r & 3);
    w2 = 2 + ((r >> 2) & 3);
    inc = (r >> 4) & 3;
    cfg[0].app = pulse_train_generation;
    cfg[0].width_count_one = w1[23:0];
    cfg[0].width_count_two = w2[23:0];
    cfg[0].reload_increment_amount = inc[7:0];
    cfg[0].output_idle_level_select = r[6];
    cfg[1] = cfg[0];
    cfg[1].output_behaviour_select = 1'b1;
    cfg[1].output_idle_level_select = 1'b0;
    cfg[1].app = frequency_shift_keying;
    cfg[1].width_count_three = 24'h000007;
    act(0, configure_and_arm);
    act(1, configure_and_arm);
    chk("idle", counter_out[0], r[6]);
    chk("fsk load", count_value[1], 24'h000007);
    i_gcu_partner_model.pulse(10'h001, w1);
    chk("low end", counter_out[0], !r[6]);
    i_gcu_partner_model.pulse(10'h001, w2);
    chk("high end", counter_out[0], r[6]);
    i_gcu_partner_model.pulse(10'h001, w1 + inc);
    chk("grown", counter_out[0], !r[6]);
    $display("test pulse train done");
    finish_test();
  end
  // cuts a hang short well beyond the expected run
  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
bind gcu_counter_pair gcu_counter_pair_checker i_gcu_counter_pair_checker (.sys_clk(sys_clk), .rst(rst),
  .cfg(cfg), .action(action), .counter_out(counter_out), .count_value(count_value), .armed(armed),
  .overflow(overflow), .point_data(point_data), .point_valid(point_valid), .point_ready(point_ready));
